// [core/lcdgr_core.sv]
// gray display memory access and drive configuration, wishbone slave
//
// Local design decisions: the address map and register access over Wishbone.
`default_nettype none
// How it works
// - six-bit contrast code 0..63 goes unchanged to the contrast output.
// - source select pin high enables on-chip gain resistors, ratio code used.
// - ratio code 0..7 gives gain 2.3 to 7.2 in steps of 0.7.
// - source select pin low disconnects on-chip resistors; gain output zero.
// - bias code 0..7 gives bias denominator 5 through 12.
// - display line count sets duty, 16 to 128 lines, single steps.
// - memory is 128 rows by 128 columns, indices 0..127.
// - every pixel holds a two-bit gray level.
// - common scan reverse flips common number to row mapping.
// - segment reverse flips segment number to column mapping.
// - scan start offset is added between rows and commons for scrolling.
// - one byte is eight rows of one column; page is row bits 6..3.
// - higher row address sits in the more significant byte bit.
// - each location moves as two accesses, upper gray bits first.
// - column advances by one after each completed byte pair.
// - commons whose row, after reversal and scroll, falls outside the line count stay unselected.
// - column loads as low four bits and high three bits separately.
module lcdgr_core (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic gainResistorSourceSel,
    output logic [5:0] contrastCode,
    output logic gainInternalEn,
    output logic [6:0] gainTenths,
    output logic [3:0] biasDenom,
    output logic [7:0] dutyLines,
    input wire logic [lcdgr_pkg::IDX_W-1:0] scanCommon,
    input wire logic [lcdgr_pkg::IDX_W-1:0] scanSegment,
    output logic [1:0] pixelGray,
    output logic commonSelected
);
    import lcdgr_pkg::*;

    lcdgr_cfg_t cfg_q, cfg_d;
    logic ack_q, phase_q, dummy_q, gainSel_q, act_q, csel_q;
    logic [31:0] dat_q, dat_d;
    logic [PAGE_W-1:0] page_q, page_d;
    logic [IDX_W-1:0] col_q, col_d;
    logic [BYTE_W-1:0] upper_q, rdByte_q;
    logic [2:0] pinSync_q, bitIdx_q;
    logic [6:0] gain_q;
    logic [3:0] bias_q;
    logic [1:0] gray_q;
    // every check runs on the core clock and sleeps during reset
    default clocking cbCore @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // bus strobes
    wire fire = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wrFire = fire & wb_we_i & wb_sel_i[0];
    wire rdFire = fire & ~wb_we_i;
    wire [7:0] wd = wb_dat_i[7:0];

    // address decode
    wire hitPage = wb_adr_i == OFS_PAGE;
    wire hitColLo = wb_adr_i == OFS_COLLO;
    wire hitColHi = wb_adr_i == OFS_COLHI;
    wire hitData = wb_adr_i == OFS_DATA;
    wire hitContrast = wb_adr_i == OFS_CONTRAST;
    wire hitRatio = wb_adr_i == OFS_RATIO;
    wire hitBias = wb_adr_i == OFS_BIAS;
    wire hitLines = wb_adr_i == OFS_LINES;
    wire hitScroll = wb_adr_i == OFS_SCROLL;
    wire hitDir = wb_adr_i == OFS_DIR;
    wire hitStatus = wb_adr_i == OFS_STATUS;

    // data port events; a byte pair completes on the second access
    wire addrSet = wrFire & (hitPage | hitColLo | hitColHi);
    wire dataWr = wrFire & hitData;
    wire dataRd = rdFire & hitData & ~dummy_q;
    wire dummyRd = rdFire & hitData & dummy_q;
    wire colStep = (dataWr | dataRd) & phase_q;

    // memory hookup: page is row bits 6..3, word per column
    wire [WADR_W-1:0] hostAdr = {page_q, col_q};
    wire [WORD_W-1:0] hostRd;
    wire memWe = dataWr & phase_q;
    wire [WORD_W-1:0] memWd = {upper_q, wd};
    wire [BYTE_W-1:0] rdSel = phase_q ? hostRd[BYTE_W-1:0]
                                      : hostRd[WORD_W-1:BYTE_W];

    // scan side mapping
    wire [IDX_W-1:0] scanRow;
    wire [IDX_W-1:0] scanCol;
    wire scanAct;
    wire [WORD_W-1:0] scanWord;
    wire [WADR_W-1:0] scanAdr = {scanRow[IDX_W-1:3], scanCol};

    lcdgr_ram u_ram (
        .core_clk(core_clk),
        .aWe(memWe),
        .aAdr(hostAdr),
        .aWdat(memWd),
        .aRdat(hostRd),
        .bAdr(scanAdr),
        .bRdat(scanWord)
    );

    lcdgr_map u_map (
        .cfg(cfg_q),
        .scanCommon(scanCommon),
        .scanSegment(scanSegment),
        .row(scanRow),
        .col(scanCol),
        .active(scanAct)
    );

    // out-of-range line counts are clamped so duty stays legal
    wire [7:0] linesIn = (wd < LINES_MIN) ? LINES_MIN
                       : (wd > LINES_MAX) ? LINES_MAX : wd;

    // configuration next state; each field loads on a hit of its offset
    assign cfg_d = '{
        contrast: wrFire & hitContrast ? wd[5:0] : cfg_q.contrast,
        ratio: wrFire & hitRatio ? wd[2:0] : cfg_q.ratio,
        bias: wrFire & hitBias ? wd[2:0] : cfg_q.bias,
        lines: wrFire & hitLines ? linesIn : cfg_q.lines,
        scroll: wrFire & hitScroll ? wd[IDX_W-1:0] : cfg_q.scroll,
        comRev: wrFire & hitDir ? wd[DIR_COM_BIT] : cfg_q.comRev,
        segRev: wrFire & hitDir ? wd[DIR_SEG_BIT] : cfg_q.segRev
    };
    property p_contrast;
        (wrFire && hitContrast) |=> (contrastCode == $past(wd[5:0]));
    endproperty
    a_contrast: assert property (p_contrast)
        else $error("contrast code not passed through");
    property p_duty;
        (wrFire && hitLines && wd < LINES_MIN) |=> (dutyLines == LINES_MIN);
    endproperty
    a_duty: assert property (p_duty)
        else $error("line count not clamped to 16");

    // address next state: split column load, auto increment wraps at 127
    assign page_d = wrFire & hitPage ? wd[PAGE_W-1:0] : page_q;
    assign col_d =
        wrFire & hitColLo ? {col_q[IDX_W-1:COLLO_W], wd[COLLO_W-1:0]}
        : wrFire & hitColHi ? {wd[COLHI_W-1:0], col_q[COLLO_W-1:0]}
        : colStep ? col_q + 7'h01 : col_q;
    property p_colstep;
        colStep |=> (col_q == $past(col_q) + 7'h01) && !phase_q;
    endproperty
    a_colstep: assert property (p_colstep)
        else $error("column did not advance after pair");
    property p_colhi;
        (wrFire && hitColHi) |=> (col_q[3:0] == $past(col_q[3:0]));
    endproperty
    a_colhi: assert property (p_colhi)
        else $error("upper column load disturbed low bits");

    // read data; unmapped offsets answer with zero
    always_comb
    begin
        dat_d = 32'h0000_0000;
        if (hitPage)
            dat_d[PAGE_W-1:0] = page_q;
        if (hitColLo)
            dat_d[COLLO_W-1:0] = col_q[COLLO_W-1:0];
        if (hitColHi)
            dat_d[COLHI_W-1:0] = col_q[IDX_W-1:COLLO_W];
        if (hitData)
            dat_d[BYTE_W-1:0] = dummy_q ? rdByte_q : rdSel;
        if (hitContrast)
            dat_d[5:0] = cfg_q.contrast;
        if (hitRatio)
            dat_d[2:0] = cfg_q.ratio;
        if (hitBias)
            dat_d[2:0] = cfg_q.bias;
        if (hitLines)
            dat_d[7:0] = cfg_q.lines;
        if (hitScroll)
            dat_d[IDX_W-1:0] = cfg_q.scroll;
        if (hitDir)
            dat_d[1:0] = {cfg_q.segRev, cfg_q.comRev};
        if (hitStatus)
            dat_d[13:0] = {dummy_q, phase_q, page_q, 1'b0, col_q};
    end

    // bus handshake: one-cycle ack, dropped the cycle after
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= fire;
            if (rdFire)
                dat_q <= dat_d;
        end
    end

    // configuration and address registers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cfg_q <= '{RST_CONTRAST, RST_RATIO, RST_BIAS, RST_LINES,
                       7'h00, 1'b0, 1'b0};
            bias_q <= BIAS_BASE + {1'b0, RST_BIAS};
            page_q <= 4'h0;
            col_q <= 7'h00;
        end
        else
        begin
            cfg_q <= cfg_d;
            bias_q <= BIAS_BASE + {1'b0, cfg_d.bias};
            page_q <= page_d;
            col_q <= col_d;
        end
    end

    property p_bias;
        (wrFire && hitBias) |=> (biasDenom == 4'h5 + {1'b0, $past(wd[2:0])});
    endproperty
    a_bias: assert property (p_bias)
        else $error("bias denominator not five plus code");

    // byte-pair sequencing; an address change restarts the pair
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            phase_q <= 1'b0;
            dummy_q <= 1'b1;
            upper_q <= 8'h00;
            rdByte_q <= 8'h00;
        end
        else
        begin
            if (addrSet)
                phase_q <= 1'b0;
            else if (dataWr || dataRd)
                phase_q <= ~phase_q;
            if (addrSet)
                dummy_q <= 1'b1;
            else if (dummyRd)
                dummy_q <= 1'b0;
            if (dataWr && !phase_q)
                upper_q <= wd;
            if (dataRd)
                rdByte_q <= rdSel;
        end
    end

    property p_dummy;
        dummyRd |=> (wb_dat_o[7:0] == $past(rdByte_q)) && !dummy_q;
    endproperty
    a_dummy: assert property (p_dummy)
        else $error("dummy read not stale byte");

    // pin crossing: three stages, a change counts when the last two agree
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pinSync_q <= 3'h0;
            gainSel_q <= 1'b0;
        end
        else
        begin
            pinSync_q <= {pinSync_q[1:0], gainResistorSourceSel};
            if (pinSync_q[1] == pinSync_q[2])
                gainSel_q <= pinSync_q[2];
        end
    end

    // gain is only defined while on-chip resistors are in the loop
    wire [6:0] gainCalc = GAIN_BASE + 7'(GAIN_STEP * {4'h0, cfg_q.ratio});
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            gain_q <= 7'h00;
        else
            gain_q <= gainSel_q ? gainCalc : 7'h00;
    end

    property p_gain;
        (gainSel_q && cfg_q.ratio == 3'h7) |=> (gainTenths == 7'h48);
    endproperty
    a_gain: assert property (p_gain)
        else $error("top gain step not 7.2");
    property p_gain_int;
        (gainSel_q && cfg_q.ratio == 3'h0) |=> (gainTenths == 7'h17);
    endproperty
    a_gain_int: assert property (p_gain_int)
        else $error("internal gain at code 0 not 2.3");
    property p_gain_ext;
        (!pinSync_q[1] && !pinSync_q[2]) |=> !gainInternalEn ##1
        (gainTenths == 7'h00);
    endproperty
    a_gain_ext: assert property (p_gain_ext)
        else $error("internal resistors not released");

    // scan pipeline: address, memory word, then pixel bit pick
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            bitIdx_q <= 3'h0;
            act_q <= 1'b0;
            gray_q <= 2'h0;
            csel_q <= 1'b0;
        end
        else
        begin
            bitIdx_q <= scanRow[2:0];
            act_q <= scanAct;
            csel_q <= act_q;
            gray_q <= act_q ? {scanWord[BYTE_W + 32'(bitIdx_q)],
                               scanWord[bitIdx_q]} : 2'h0;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign contrastCode = cfg_q.contrast;
    assign gainInternalEn = gainSel_q;
    assign gainTenths = gain_q;
    assign biasDenom = bias_q;
    assign dutyLines = cfg_q.lines;
    assign pixelGray = gray_q;
    assign commonSelected = csel_q;
endmodule
`default_nettype wire

// [core/lcdgr_pkg.sv]
// shared constants, register map and carrier types for the gray display core
`default_nettype none
package lcdgr_pkg;
    // memory geometry: 16 pages of 128 columns, one 16-bit word per byte pair
    localparam int IDX_W = 7;
    localparam int PAGE_W = 4;
    localparam int WADR_W = 11;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [6:0] IDX_MAX = 7'h7F;

    // register byte offsets on the bus
    localparam logic [7:0] OFS_PAGE = 8'h00;
    localparam logic [7:0] OFS_COLLO = 8'h04;
    localparam logic [7:0] OFS_COLHI = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0C;
    localparam logic [7:0] OFS_CONTRAST = 8'h10;
    localparam logic [7:0] OFS_RATIO = 8'h14;
    localparam logic [7:0] OFS_BIAS = 8'h18;
    localparam logic [7:0] OFS_LINES = 8'h1C;
    localparam logic [7:0] OFS_SCROLL = 8'h20;
    localparam logic [7:0] OFS_DIR = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;

    // reset values
    localparam logic [5:0] RST_CONTRAST = 6'h20;
    localparam logic [2:0] RST_RATIO = 3'h0;
    localparam logic [2:0] RST_BIAS = 3'h0;
    localparam logic [7:0] RST_LINES = 8'h80;

    // drive decode figures: gain in tenths, bias denominator, duty limits
    localparam logic [6:0] GAIN_BASE = 7'h17;
    localparam logic [6:0] GAIN_STEP = 7'h07;
    localparam logic [3:0] BIAS_BASE = 4'h5;
    localparam logic [7:0] LINES_MIN = 8'h10;
    localparam logic [7:0] LINES_MAX = 8'h80;

    // field positions inside register words
    localparam int DIR_COM_BIT = 0;
    localparam int DIR_SEG_BIT = 1;
    localparam int COLHI_W = 3;
    localparam int COLLO_W = 4;

    typedef struct packed {
        logic [5:0] contrast;
        logic [2:0] ratio;
        logic [2:0] bias;
        logic [7:0] lines;
        logic [6:0] scroll;
        logic comRev;
        logic segRev;
    } lcdgr_cfg_t;
endpackage
`default_nettype wire

// [core/lcdgr_ram.sv]
// display memory: one read/write host port and one read-only scan port
`default_nettype none
module lcdgr_ram (
    input wire logic core_clk,
    input wire logic aWe,
    input wire logic [lcdgr_pkg::WADR_W-1:0] aAdr,
    input wire logic [lcdgr_pkg::WORD_W-1:0] aWdat,
    output logic [lcdgr_pkg::WORD_W-1:0] aRdat,
    input wire logic [lcdgr_pkg::WADR_W-1:0] bAdr,
    output logic [lcdgr_pkg::WORD_W-1:0] bRdat
);
    import lcdgr_pkg::*;

    // upper byte holds the high gray bits, lower byte the low gray bits
    logic [WORD_W-1:0] mem [2**WADR_W];

    // host port: read returns the word before this edge's write
    always_ff @(posedge core_clk)
    begin
        if (aWe)
        begin
            mem[aAdr] <= aWdat;
        end
        aRdat <= mem[aAdr];
    end

    // scan port, registered read
    always_ff @(posedge core_clk)
    begin
        bRdat <= mem[bAdr];
    end
endmodule
`default_nettype wire

// [core/lcdgr_map.sv]
// maps common and segment output numbers onto memory row and column
`default_nettype none
module lcdgr_map (
    input wire lcdgr_pkg::lcdgr_cfg_t cfg,
    input wire logic [lcdgr_pkg::IDX_W-1:0] scanCommon,
    input wire logic [lcdgr_pkg::IDX_W-1:0] scanSegment,
    output logic [lcdgr_pkg::IDX_W-1:0] row,
    output logic [lcdgr_pkg::IDX_W-1:0] col,
    output logic active
);
    import lcdgr_pkg::*;

    logic [IDX_W-1:0] comEff;
    logic [IDX_W-1:0] rel;

    // reversal first, then scroll offset; 7-bit subtract wraps modulo 128
    assign comEff = cfg.comRev ? IDX_MAX - scanCommon : scanCommon;
    assign rel = comEff - cfg.scroll;
    assign row = rel;
    // lines past the count stay unselected in partial display
    assign active = {1'b0, rel} < cfg.lines;
    assign col = cfg.segRev ? IDX_MAX - scanSegment : scanSegment;
endmodule
`default_nettype wire

// [test/lcdgr_host.sv]
// host model: classic wishbone master issuing commands and data
`default_nettype none
module lcdgr_host (
    input wire logic core_clk,
    output logic wbCyc,
    output logic wbStb,
    output logic wbWe,
    output logic [7:0] wbAdr,
    output logic [3:0] wbSel,
    output logic [31:0] wbDatW,
    input wire logic [31:0] wbDatR,
    input wire logic wbAck
);
    timeunit 1ns;
    timeprecision 1ps;
    import lcdgr_pkg::*;

    // idle bus from time zero
    initial
    begin
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDatW = 32'h00000000;
    end

    // one classic cycle; request held until ack is sampled high
    task automatic busCycle(input logic wr, input logic [7:0] adr,
                            input logic [7:0] dat, output logic [31:0] rd);
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= wr;
        wbAdr <= adr;
        wbSel <= 4'hF;
        wbDatW <= {24'h000000, dat};
        @(posedge core_clk);
        while (wbAck !== 1'b1)
            @(posedge core_clk);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    task automatic write(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] unused;
        busCycle(1'b1, adr, dat, unused);
    endtask

    task automatic read(input logic [7:0] adr, output logic [31:0] rd);
        busCycle(1'b0, adr, 8'h00, rd);
    endtask

    // address always set before any data access
    task automatic setAddr(input logic [3:0] page, input logic [6:0] col);
        write(OFS_PAGE, {4'h0, page});
        write(OFS_COLLO, {4'h0, col[3:0]});
        write(OFS_COLHI, {5'h00, col[6:4]});
    endtask
endmodule
`default_nettype wire

// [test/lcdgr_core_bench.sv]
// self-checking bench for the gray display core
`default_nettype none
module lcdgr_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import lcdgr_pkg::*;

    logic core_clk, rst_n, gainResistorSourceSel;
    logic [6:0] scanCommon, scanSegment;
    logic wbCyc, wbStb, wbWe, wbAck, gainInternalEn, commonSelected;
    logic [7:0] wbAdr, dutyLines;
    logic [3:0] wbSel, biasDenom;
    logic [31:0] wbDatW, wbDatR, rd;
    logic [5:0] contrastCode;
    logic [6:0] gainTenths;
    logic [1:0] pixelGray;
    logic [7:0] hi0 = 8'hA5, lo0 = 8'h3C, hi1 = 8'h0F, lo1 = 8'hF0;
    int errors = 0;
    int num_checks = 0;

    lcdgr_host i_host (.core_clk(core_clk), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
        .wbDatR(wbDatR), .wbAck(wbAck));

    lcdgr_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
        .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck), .gainResistorSourceSel(gainResistorSourceSel),
        .contrastCode(contrastCode), .gainInternalEn(gainInternalEn),
        .gainTenths(gainTenths), .biasDenom(biasDenom),
        .dutyLines(dutyLines), .scanCommon(scanCommon),
        .scanSegment(scanSegment), .pixelGray(pixelGray),
        .commonSelected(commonSelected));

    // 40 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever
            #12.5 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // registered outputs land on the same edge that raises the bus answer
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic testReset();
        check("contrast", contrastCode, 32'h20);
        check("bias", biasDenom, 32'h5);
        check("lines", dutyLines, 32'h80);
        check("gain", gainTenths, 32'h0);
    endtask

    task automatic testContrast();
        i_host.write(OFS_CONTRAST, 8'h00);
        settle();
        check("contrast", contrastCode, 32'h00);
        i_host.write(OFS_CONTRAST, 8'h3F);
        settle();
        check("contrast", contrastCode, 32'h3F);
    endtask

    // pin is synchronised, so wait past its three-stage chain
    task automatic testGain();
        @(posedge core_clk);
        gainResistorSourceSel <= 1'b1;
        for (int r = 0; r < 8; r++)
        begin
            i_host.write(OFS_RATIO, 8'(r));
            repeat (5) @(posedge core_clk);
            #1;
            check("gainEn", gainInternalEn, 32'h1);
            check("gain", gainTenths, 7'h17 + 7'h07 * 7'(r));
        end
        @(posedge core_clk);
        gainResistorSourceSel <= 1'b0;
        repeat (6) @(posedge core_clk);
        #1;
        check("gainEn", gainInternalEn, 32'h0);
        check("gain", gainTenths, 32'h0);
    endtask

    task automatic testBias();
        for (int b = 0; b < 8; b++)
        begin
            i_host.write(OFS_BIAS, 8'(b));
            settle();
            check("bias", biasDenom, 4'h5 + 4'(b));
        end
    endtask

    // boundaries and out-of-range counts
    task automatic testLines();
        logic [7:0] wr [4] = '{8'h10, 8'h08, 8'h81, 8'h80};
        logic [7:0] ex [4] = '{8'h10, 8'h10, 8'h80, 8'h80};
        for (int i = 0; i < 4; i++)
        begin
            i_host.write(OFS_LINES, wr[i]);
            settle();
            check("lines", dutyLines, ex[i]);
        end
    endtask

    // last column then wrap to column zero, then read back
    task automatic testMemory();
        i_host.setAddr(4'h2, 7'h7F);
        i_host.write(OFS_DATA, hi0);
        i_host.write(OFS_DATA, lo0);
        i_host.read(OFS_STATUS, rd);
        check("wrap", rd[6:0], 32'h00);
        i_host.write(OFS_DATA, hi1);
        i_host.write(OFS_DATA, lo1);
        i_host.read(OFS_STATUS, rd);
        check("status", rd[6:0], 32'h01);
        i_host.setAddr(4'h2, 7'h7F);
        i_host.read(OFS_STATUS, rd);
        check("status", rd[13:0], 32'h227F);
        i_host.read(OFS_DATA, rd);
        check("dummy", rd[7:0], 32'h00);
        i_host.read(OFS_STATUS, rd);
        check("status", rd[13:0], 32'h027F);
        i_host.read(OFS_DATA, rd);
        check("hi0", rd[7:0], hi0);
        i_host.read(OFS_DATA, rd);
        check("lo0", rd[7:0], lo0);
        i_host.read(OFS_DATA, rd);
        check("hi1", rd[7:0], hi1);
    endtask

    task automatic scanAt(input logic [6:0] c, s, input logic [1:0] g,
                          input logic sel);
        @(posedge core_clk);
        scanCommon <= c;
        scanSegment <= s;
        repeat (2) @(posedge core_clk);
        #1;
        check("gray", pixelGray, g);
        check("selected", commonSelected, sel);
    endtask

    // page 2 holds rows 16..23; bit n of a byte is row 16+n
    task automatic testScan();
        for (int n = 0; n < 8; n++)
            scanAt(7'(16 + n), 7'h7F, {hi0[n], lo0[n]}, 1'b1);
        scanAt(7'h10, 7'h00, {hi1[0], lo1[0]}, 1'b1);
        i_host.write(OFS_DIR, 8'h01);
        scanAt(7'h6F, 7'h7F, {hi0[0], lo0[0]}, 1'b1);
        i_host.write(OFS_DIR, 8'h02);
        scanAt(7'h10, 7'h00, {hi0[0], lo0[0]}, 1'b1);
        i_host.write(OFS_DIR, 8'h00);
        i_host.write(OFS_SCROLL, 8'h05);
        scanAt(7'h15, 7'h7F, {hi0[0], lo0[0]}, 1'b1);
        i_host.write(OFS_SCROLL, 8'h78);
        scanAt(7'h08, 7'h7F, {hi0[0], lo0[0]}, 1'b1);
        i_host.write(OFS_SCROLL, 8'h00);
        i_host.write(OFS_LINES, 8'h10);
        scanAt(7'h10, 7'h7F, 2'h0, 1'b0);
        scanAt(7'h7F, 7'h7F, 2'h0, 1'b0);
    endtask

    // hang guard, well past the expected run length
    initial
    begin
        repeat (20000) @(posedge core_clk);
        errors++;
        print_verdict();
    end

    // reset held three cycles, then the scenarios
    initial
    begin
        rst_n = 1'b0;
        gainResistorSourceSel = 1'b0;
        scanCommon = 7'h00;
        scanSegment = 7'h00;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        testReset();
        testContrast();
        testGain();
        testBias();
        testLines();
        testMemory();
        testScan();
        print_verdict();
    end
endmodule
`default_nettype wire
